// ==== common/bau_defines.vh ====
// constants shared by the bcd arithmetic unit
`ifndef BAU_DEFINES_VH
`define BAU_DEFINES_VH

// ----------------------------------------
// operand shapes
// ----------------------------------------
`define BAU_DIV_DIGITS   4
`define BAU_WIDE_DIGITS  8
`define BAU_DIV_BIN_W    14
`define BAU_WIDE_BIN_W   28

// ----------------------------------------
// limits
// ----------------------------------------
`define BAU_WIDE_MAX_BCD 32'h99999999
`define BAU_WIDE_MIN_BCD 32'h00000000
`define BAU_WIDE_MAX_BIN 28'h5F5E0FF
`define BAU_DIV_ZERO_BIN 14'h0000

// ----------------------------------------
// function codes of the three operations
// ----------------------------------------
`define BAU_DIVIDE_FUNCTION_CODE   8'hC3
`define BAU_WIDE_ADD_FUNCTION_CODE 8'hC4
`define BAU_WIDE_SUB_FUNCTION_CODE 8'hC5

`endif

// ==== design/bau_bcd2bin.v ====
// bcd word to binary with a digit range check
`timescale 1ns/10ps
`default_nettype none

module bau_bcd2bin #(
  parameter ND = 4,
  parameter BW = 14
) (
  input  wire [4*ND-1:0] bcd,
  output reg  [BW-1:0]   bin,
  output reg             valid
);

  // ----------------------------------------
  // horner accumulation, most significant digit first
  // ----------------------------------------
  integer i;
  reg [3:0] dig;

  always @* begin
    bin   = {BW{1'b0}};
    valid = 1'b1;
    dig   = 4'h0;
    for (i = ND-1; i >= 0; i = i - 1) begin
      dig = bcd[4*i +: 4];
      if (dig > 4'h9) begin
        valid = 1'b0;
      end
      bin = bin * 4'hA + {{(BW-4){1'b0}}, dig};
    end
  end

endmodule

`default_nettype wire

// ==== design/bau_bin2bcd.v ====
// binary to bcd by shift and add three
`timescale 1ns/10ps
`default_nettype none

module bau_bin2bcd #(
  parameter BW = 14,
  parameter ND = 4
) (
  input  wire [BW-1:0]   bin,
  output reg  [4*ND-1:0] bcd
);

  // ----------------------------------------
  // double dabble; caller keeps bin below 10**ND
  // ----------------------------------------
  integer i;
  integer d;

  always @* begin
    bcd = {4*ND{1'b0}};
    for (i = BW-1; i >= 0; i = i - 1) begin
      for (d = 0; d < ND; d = d + 1) begin
        if (bcd[4*d +: 4] > 4'h4) begin
          bcd[4*d +: 4] = bcd[4*d +: 4] + 4'h3;
        end
      end
      bcd = {bcd[4*ND-2:0], bin[i]};
    end
  end

endmodule

`default_nettype wire

// ==== design/bau_bcd_arith_unit.v ====
// bcd divide, saturating wide add and wide subtract datapath
`timescale 1ns/10ps
`default_nettype none
`include "bau_defines.vh"

module bau_bcd_arith_unit #(
  parameter DIV_ND  = `BAU_DIV_DIGITS,
  parameter WIDE_ND = `BAU_WIDE_DIGITS
) (
  input  wire                 mclk,
  input  wire                 srst,
  input  wire                 ce,
  // divide
  input  wire                 div_en,
  input  wire [4*DIV_ND-1:0]  div_dividend,
  input  wire [4*DIV_ND-1:0]  div_divisor,
  output reg  [4*DIV_ND-1:0]  div_quotient,
  output reg  [4*DIV_ND-1:0]  div_remainder,
  output reg                  div_done,
  // wide add, high word in the upper half
  input  wire                 bcd_wide_add_op,
  input  wire [4*WIDE_ND-1:0] add_augend,
  input  wire [4*WIDE_ND-1:0] add_addend,
  output reg  [4*WIDE_ND-1:0] add_sum,
  output reg                  add_overflow,
  // wide subtract, high word in the upper half
  input  wire                 bcd_wide_sub_op,
  input  wire [4*WIDE_ND-1:0] sub_minuend,
  input  wire [4*WIDE_ND-1:0] sub_subtrahend,
  output reg  [4*WIDE_ND-1:0] sub_difference,
  output reg                  sub_underflow,
  // sticky error flags
  input  wire                 err_clear,
  output reg                  err_bcd,
  output reg                  err_div
);

  localparam DBW = `BAU_DIV_BIN_W;
  localparam WBW = `BAU_WIDE_BIN_W;

  // ----------------------------------------
  // divide operands to binary
  // ----------------------------------------
  wire [DBW-1:0] dvd_bin;
  wire [DBW-1:0] dvs_bin;
  wire           dvd_ok;
  wire           dvs_ok;

  bau_bcd2bin #(
    .ND (DIV_ND),
    .BW (DBW)
  ) u_dvd (
    .bcd   (div_dividend),
    .bin   (dvd_bin),
    .valid (dvd_ok)
  );

  bau_bcd2bin #(
    .ND (DIV_ND),
    .BW (DBW)
  ) u_dvs (
    .bcd   (div_divisor),
    .bin   (dvs_bin),
    .valid (dvs_ok)
  );

  // ----------------------------------------
  // divide core
  // ----------------------------------------
  wire           div_digits_ok;
  wire           div_zero;
  wire           div_go;
  wire [DBW-1:0] safe_dvs;
  wire [DBW-1:0] quo_bin;
  wire [DBW-1:0] rem_bin;
  wire [4*DIV_ND-1:0] quo_bcd;
  wire [4*DIV_ND-1:0] rem_bcd;

  assign div_digits_ok = dvd_ok & dvs_ok;
  assign div_zero      = (dvs_bin == `BAU_DIV_ZERO_BIN);
  assign div_go        = div_en & div_digits_ok & ~div_zero;
  // divisor forced to one when zero so the divider never sees zero
  assign safe_dvs      = div_zero ? {{(DBW-1){1'b0}}, 1'b1} : dvs_bin;
  assign quo_bin       = dvd_bin / safe_dvs;
  assign rem_bin       = dvd_bin % safe_dvs;

  bau_bin2bcd #(
    .BW (DBW),
    .ND (DIV_ND)
  ) u_quo (
    .bin (quo_bin),
    .bcd (quo_bcd)
  );

  bau_bin2bcd #(
    .BW (DBW),
    .ND (DIV_ND)
  ) u_rem (
    .bin (rem_bin),
    .bcd (rem_bcd)
  );

  // ----------------------------------------
  // wide add operands and core
  // ----------------------------------------
  wire [WBW-1:0] aug_bin;
  wire [WBW-1:0] adn_bin;
  wire           aug_ok;
  wire           adn_ok;

  bau_bcd2bin #(
    .ND (WIDE_ND),
    .BW (WBW)
  ) u_aug (
    .bcd   (add_augend),
    .bin   (aug_bin),
    .valid (aug_ok)
  );

  bau_bcd2bin #(
    .ND (WIDE_ND),
    .BW (WBW)
  ) u_adn (
    .bcd   (add_addend),
    .bin   (adn_bin),
    .valid (adn_ok)
  );

  wire           add_digits_ok;
  wire           add_go;
  wire [WBW-1:0] sum_raw;
  wire           sum_over;
  wire [WBW-1:0] sum_sat;
  wire [4*WIDE_ND-1:0] sum_bcd;

  assign add_digits_ok = aug_ok & adn_ok;
  assign add_go        = bcd_wide_add_op & add_digits_ok;
  // two eight digit values stay below 2**28, no carry lost
  assign sum_raw       = aug_bin + adn_bin;
  assign sum_over      = (sum_raw > `BAU_WIDE_MAX_BIN);
  assign sum_sat       = sum_over ? `BAU_WIDE_MAX_BIN : sum_raw;

  bau_bin2bcd #(
    .BW (WBW),
    .ND (WIDE_ND)
  ) u_sum (
    .bin (sum_sat),
    .bcd (sum_bcd)
  );

  // ----------------------------------------
  // wide subtract operands and core
  // ----------------------------------------
  wire [WBW-1:0] min_bin;
  wire [WBW-1:0] sbt_bin;
  wire           min_ok;
  wire           sbt_ok;

  bau_bcd2bin #(
    .ND (WIDE_ND),
    .BW (WBW)
  ) u_min (
    .bcd   (sub_minuend),
    .bin   (min_bin),
    .valid (min_ok)
  );

  bau_bcd2bin #(
    .ND (WIDE_ND),
    .BW (WBW)
  ) u_sbt (
    .bcd   (sub_subtrahend),
    .bin   (sbt_bin),
    .valid (sbt_ok)
  );

  wire           sub_digits_ok;
  wire           sub_go;
  wire           sub_neg;
  wire [WBW-1:0] diff_raw;
  wire [4*WIDE_ND-1:0] diff_bcd;

  assign sub_digits_ok = min_ok & sbt_ok;
  assign sub_go        = bcd_wide_sub_op & sub_digits_ok;
  assign sub_neg       = (min_bin < sbt_bin);
  // clamp before conversion so a wrapped value never reaches the digits
  assign diff_raw      = sub_neg ? {WBW{1'b0}} : min_bin - sbt_bin;

  bau_bin2bcd #(
    .BW (WBW),
    .ND (WIDE_ND)
  ) u_diff (
    .bin (diff_raw),
    .bcd (diff_bcd)
  );

  // ----------------------------------------
  // sticky error flags
  // ----------------------------------------
  reg next_err_bcd;
  reg next_err_div;

  always @* begin
    // a new error in the clearing cycle wins over the clear
    next_err_bcd = err_bcd & ~err_clear;
    next_err_div = err_div & ~err_clear;
    if (div_en && !div_digits_ok) begin
      next_err_bcd = 1'b1;
    end
    if (div_en && div_digits_ok && div_zero) begin
      next_err_div = 1'b1;
    end
    if (bcd_wide_add_op && !add_digits_ok) begin
      next_err_bcd = 1'b1;
    end
    if (bcd_wide_sub_op && !sub_digits_ok) begin
      next_err_bcd = 1'b1;
    end
  end

  // ----------------------------------------
  // divide destination and execution output
  // ----------------------------------------
  // results change on the one edge that takes the operation
  // skipped operations leave destinations as they were
  always @(posedge mclk) begin
    if (srst) begin
      div_quotient  <= {4*DIV_ND{1'b0}};
      div_remainder <= {4*DIV_ND{1'b0}};
      div_done      <= 1'b0;
    end else if (ce) begin
      if (div_go) begin
        div_quotient  <= quo_bcd;
        div_remainder <= rem_bcd;
      end
      div_done <= div_go;
    end
  end

  // ----------------------------------------
  // wide add destination and overflow output
  // ----------------------------------------
  // a saturated sum is written like any other result
  always @(posedge mclk) begin
    if (srst) begin
      add_sum      <= `BAU_WIDE_MIN_BCD;
      add_overflow <= 1'b0;
    end else if (ce) begin
      if (add_go) begin
        add_sum <= sum_bcd;
      end
      add_overflow <= add_go & sum_over;
    end
  end

  // ----------------------------------------
  // wide subtract destination and underflow output
  // ----------------------------------------
  // an exact zero difference is not an underflow
  always @(posedge mclk) begin
    if (srst) begin
      sub_difference <= `BAU_WIDE_MIN_BCD;
      sub_underflow  <= 1'b0;
    end else if (ce) begin
      if (sub_go) begin
        sub_difference <= diff_bcd;
      end
      sub_underflow <= sub_go & sub_neg;
    end
  end

  // ----------------------------------------
  // error flag registers
  // ----------------------------------------
  // frozen with ce low like every other bit of state
  always @(posedge mclk) begin
    if (srst) begin
      err_bcd <= 1'b0;
      err_div <= 1'b0;
    end else if (ce) begin
      err_bcd <= next_err_bcd;
      err_div <= next_err_div;
    end
  end

endmodule

`default_nettype wire

// ==== bench/bau_seq_model.sv ====
// instruction sequencer model feeding operands and enables
`timescale 1ns/10ps
`default_nettype none
module bau_seq_model (
  input  wire logic        mclk,
  output logic      [2:0]  en,
  output logic      [31:0] opa,
  output logic      [31:0] opb
);
  initial begin
    en = 3'h0;
    opa = 32'h0;
    opb = 32'h0;
  end
  // one op per call; released operands turn to junk so nothing leans on them
  task automatic run(input logic [2:0] sel, input logic [31:0] a, b);
    @(negedge mclk);
    en = sel;
    opa = a;
    opb = b;
    @(negedge mclk);
    en = 3'h0;
    opa = ~a;
    opb = ~b;
  endtask
endmodule
`default_nettype wire

// ==== bench/bau_arith_assertions.sv ====
// port assertions for the bcd arithmetic unit
`timescale 1ns/10ps
`default_nettype none
module bau_arith_chk #(
  parameter DIV_ND  = 4,
  parameter WIDE_ND = 8
) (
  input wire logic                 mclk,
  input wire logic                 srst,
  input wire logic                 ce,
  input wire logic                 div_en,
  input wire logic [4*DIV_ND-1:0]  div_divisor,
  input wire logic                 div_done,
  input wire logic                 bcd_wide_add_op,
  input wire logic [4*WIDE_ND-1:0] add_sum,
  input wire logic                 add_overflow,
  input wire logic                 bcd_wide_sub_op,
  input wire logic [4*WIDE_ND-1:0] sub_difference,
  input wire logic                 sub_underflow,
  input wire logic                 err_clear,
  input wire logic                 err_bcd,
  input wire logic                 err_div
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  chk_done_idle: assert property (
    ce && !div_en |=> !div_done)
    else $error("divide done while idle");
  chk_zero_div: assert property (
    ce && div_en && div_divisor == 0 |=> !div_done)
    else $error("divide done on zero divisor");
  chk_ovf_sat: assert property (
    add_overflow |-> add_sum == 32'h99999999)
    else $error("overflow without limit sum");
  chk_unf_zero: assert property (
    sub_underflow |-> sub_difference == 32'h00000000)
    else $error("underflow without zero");
  chk_add_hold: assert property (
    ce && !bcd_wide_add_op |=> $stable(add_sum) && !add_overflow)
    else $error("idle add changed");
  chk_sub_hold: assert property (
    ce && !bcd_wide_sub_op |=> $stable(sub_difference) && !sub_underflow)
    else $error("idle subtract changed");
  chk_bcd_sticky: assert property (
    err_bcd && !err_clear |=> err_bcd)
    else $error("bcd error dropped");
  chk_div_sticky: assert property (
    err_div && !err_clear |=> err_div)
    else $error("divide error dropped");
  chk_clr_errs: assert property (
    ce && err_clear && !div_en && !bcd_wide_add_op && !bcd_wide_sub_op
    |=> !err_bcd && !err_div)
    else $error("errors not cleared");
endmodule
bind bau_bcd_arith_unit bau_arith_chk #(
  .DIV_ND(DIV_ND), .WIDE_ND(WIDE_ND)
) i_bau_arith_chk (
  .mclk(mclk), .srst(srst), .ce(ce), .div_en(div_en),
  .div_divisor(div_divisor), .div_done(div_done),
  .bcd_wide_add_op(bcd_wide_add_op), .add_sum(add_sum),
  .add_overflow(add_overflow), .bcd_wide_sub_op(bcd_wide_sub_op),
  .sub_difference(sub_difference), .sub_underflow(sub_underflow),
  .err_clear(err_clear), .err_bcd(err_bcd), .err_div(err_div));
`default_nettype wire

// ==== bench/test_bcd_arith_unit.sv ====
// self-checking bench for the bcd arithmetic unit
`timescale 1ns/10ps
`default_nettype none
module test_bcd_arith_unit;
  logic        mclk = 1'b0;
  logic        srst = 1'b1;
  logic        ce = 1'b1;
  logic        err_clear = 1'b0;
  logic [2:0]  en;
  logic [31:0] opa, opb, add_sum, sub_difference;
  logic [15:0] div_quotient, div_remainder;
  logic        div_done, add_overflow, sub_underflow, err_bcd, err_div;
  int          err_total = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  always #10 mclk = ~mclk;
  bau_seq_model i_bau_seq_model (.mclk(mclk), .en(en), .opa(opa), .opb(opb));
  bau_bcd_arith_unit i_bau_bcd_arith_unit (
    .mclk(mclk), .srst(srst), .ce(ce), .div_en(en[0]),
    .div_dividend(opa[15:0]), .div_divisor(opb[15:0]),
    .div_quotient(div_quotient), .div_remainder(div_remainder),
    .div_done(div_done), .bcd_wide_add_op(en[1]), .add_augend(opa),
    .add_addend(opb), .add_sum(add_sum), .add_overflow(add_overflow),
    .bcd_wide_sub_op(en[2]), .sub_minuend(opa), .sub_subtrahend(opb),
    .sub_difference(sub_difference), .sub_underflow(sub_underflow),
    .err_clear(err_clear), .err_bcd(err_bcd), .err_div(err_div));
  task automatic summarize;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmpf(input logic got, exp);
    cmp({31'h0, got}, {31'h0, exp});
  endtask
  // divide result packs remainder above quotient
  task automatic op(input logic [2:0] s, input logic [31:0] a, b, r,
                    input logic f);
    i_bau_seq_model.run(s, a, b);
    if (s == 3'h1) begin
      cmp({div_remainder, div_quotient}, r);
      cmpf(div_done, f);
    end else if (s == 3'h2) begin
      cmp(add_sum, r);
      cmpf(add_overflow, f);
    end else begin
      cmp(sub_difference, r);
      cmpf(sub_underflow, f);
    end
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 500) begin
      err_total++;
      summarize();
    end
  end
  initial begin
    repeat (6) @(negedge mclk);
    srst = 1'b0;
    cmpf(err_bcd, 1'b0);
    op(3'h1, 32'h8765, 32'h0021, 32'h00080417, 1'b1);
    @(negedge mclk);
    cmpf(div_done, 1'b0);
    cmp({div_remainder, div_quotient}, 32'h00080417);
    op(3'h1, 32'h1234, 32'h0000, 32'h00080417, 1'b0);
    cmpf(err_div, 1'b1);
    op(3'h1, 32'h9999, 32'h0001, 32'h00009999, 1'b1);
    cmpf(err_div, 1'b1);
    op(3'h1, 32'h00A0, 32'h0003, 32'h00009999, 1'b0);
    cmpf(err_bcd, 1'b1);
    // clear overlapping a fresh divide error: the new error wins
    err_clear = 1'b1;
    op(3'h1, 32'h1234, 32'h0000, 32'h00009999, 1'b0);
    cmpf(err_div, 1'b1);
    cmpf(err_bcd, 1'b0);
    @(negedge mclk);
    err_clear = 1'b0;
    cmpf(err_bcd | err_div, 1'b0);
    op(3'h2, 32'h47513664, 32'h42887647, 32'h90401311, 1'b0);
    op(3'h2, 32'h00000001, 32'h99999998, 32'h99999999, 1'b0);
    op(3'h2, 32'h99999999, 32'h00000001, 32'h99999999, 1'b1);
    // ce low must freeze the saturated result and its overflow
    ce = 1'b0;
    op(3'h2, 32'h00000001, 32'h00000002, 32'h99999999, 1'b1);
    ce = 1'b1;
    op(3'h2, 32'h1234567F, 32'h00000001, 32'h99999999, 1'b0);
    cmpf(err_bcd, 1'b1);
    err_clear = 1'b1;
    @(negedge mclk);
    err_clear = 1'b0;
    op(3'h4, 32'h49210162, 32'h20985748, 32'h28224414, 1'b0);
    op(3'h4, 32'hB0000000, 32'h00000001, 32'h28224414, 1'b0);
    cmpf(err_bcd, 1'b1);
    op(3'h4, 32'h55555555, 32'h55555555, 32'h00000000, 1'b0);
    op(3'h4, 32'h00000002, 32'h00000003, 32'h00000000, 1'b1);
    summarize();
  end
endmodule
`default_nettype wire
